// File: logic/hdlc_status_map.vh
`ifndef HDLC_STATUS_MAP_VH
`define HDLC_STATUS_MAP_VH

// Register indices as printed; byte address is four times the index
`define STATUS_REG_INDEX 6'h01
`define ENABLE_REG_INDEX 6'h02

// Field positions shared by the status and the enable register
`define BIT_CODE_CHANGE 7
`define BIT_RX_PACKET_END 6
`define BIT_RX_PACKET_START 5
`define BIT_RX_HALF_FULL 4
`define BIT_RX_NOT_EMPTY 3
`define BIT_TX_HALF_EMPTY 2
`define BIT_TX_HAS_ROOM 1
`define BIT_TX_MESSAGE_DONE 0

// Mask of the bits that latch and clear on read
`define LATCHED_MASK 8'hE1

// Reset values
`define ENABLE_RESET 8'h00
`define STATUS_RESET 8'h00

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// FIFO capacity in bytes
`define FIFO_BYTES 64

`endif

// File: logic/hdlc_event_latch.v
// One sticky event flag; a set in the clearing cycle wins
module hdlc_event_latch (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_set,
  input wire i_clear,
  output wire o_flag
);

  reg flag_reg; // Latched event
  reg flag_next; // Its next value

  // Set has priority so an event coinciding with a clear survives
  always @* begin
    flag_next = flag_reg;
    if (i_set) begin
      flag_next = 1'b1;
    end else if (i_clear) begin
      flag_next = 1'b0;
    end
  end

  // State update
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign o_flag = flag_reg;

endmodule

// File: logic/hdlc_status_interrupt_mask.v
// Design decision made here: the AXI4-Lite interface to the registers.
`include "hdlc_status_map.vh"

module hdlc_status_interrupt_mask #(
  parameter ADDR_W = 8, // Byte address width of the bus
  parameter FIFO_DEPTH = `FIFO_BYTES, // Bytes in each FIFO
  parameter CNT_W = 7 // Width of the occupancy counts
) (
  input wire I_MCLK,
  input wire I_RESET_N,
  // Events from the HDLC and code datapath
  input wire i_code_detected,
  input wire i_rx_message_valid,
  input wire i_rx_crc_error,
  input wire i_rx_overrun,
  input wire i_rx_abort,
  input wire i_rx_opening_byte,
  input wire [CNT_W-1:0] i_rx_fifo_count,
  input wire [CNT_W-1:0] i_tx_fifo_count,
  input wire i_tx_message_done,
  // Interrupt to the host
  output wire O_INT_N,
  // AXI4-Lite write address
  input wire I_AWVALID,
  output wire O_AWREADY,
  input wire [ADDR_W-1:0] I_AWADDR,
  input wire [2:0] I_AWPROT,
  // AXI4-Lite write data
  input wire I_WVALID,
  output wire O_WREADY,
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  // AXI4-Lite write response
  output wire O_BVALID,
  input wire I_BREADY,
  output wire [1:0] O_BRESP,
  // AXI4-Lite read address
  input wire I_ARVALID,
  output wire O_ARREADY,
  input wire [ADDR_W-1:0] I_ARADDR,
  input wire [2:0] I_ARPROT,
  // AXI4-Lite read data
  output wire O_RVALID,
  input wire I_RREADY,
  output wire [31:0] O_RDATA,
  output wire [1:0] O_RRESP
);

  // Half-way point of a FIFO, in bytes, worked out at full width
  localparam [31:0] HALF_WIDE = FIFO_DEPTH / 2;
  localparam [31:0] FULL_WIDE = FIFO_DEPTH;
  // Cut to the count width on purpose; a count never exceeds the depth
  localparam [CNT_W-1:0] HALF_LEVEL = HALF_WIDE[CNT_W-1:0];
  localparam [CNT_W-1:0] FULL_LEVEL = FULL_WIDE[CNT_W-1:0];

  // Write channel state
  reg aw_held_reg; // Write address taken, awaiting data
  reg [ADDR_W-1:0] aw_addr_reg; // Held write address
  reg w_held_reg; // Write data taken, awaiting address
  reg [31:0] w_data_reg; // Held write data
  reg [3:0] w_strb_reg; // Held byte enables
  reg bvalid_reg; // Write answer pending
  reg [1:0] bresp_reg; // Write answer code

  // Read channel state
  reg rvalid_reg; // Read answer pending
  reg [31:0] rdata_reg; // Read answer data
  reg [1:0] rresp_reg; // Read answer code

  // Block state
  reg [7:0] enable_reg; // Per-flag interrupt enables
  reg code_prev_reg; // Detector state one cycle ago
  reg [3:0] level_reg; // Live FIFO level flags
  reg [3:0] level_next; // Their next value
  wire [3:0] latched; // Sticky event flags
  wire [3:0] latch_set; // Event pulses into the latches
  wire [3:0] latch_clear; // Clear requests to the latches
  wire [7:0] status; // Assembled status register
  wire [3:0] latched_next; // Sticky flags as they stand after this edge
  wire [7:0] enable_next; // Enables as they stand after this edge
  wire [7:0] status_next; // Status as it stands after this edge
  reg int_n_reg; // Registered interrupt pin

  // Handshake terms
  wire aw_take; // Address handshake this edge
  wire w_take; // Data handshake this edge
  wire ar_take; // Read address handshake this edge
  wire aw_ok; // Address available for a write
  wire w_ok; // Data available for a write
  wire do_write; // Write is carried out this edge
  wire [ADDR_W-1:0] wr_addr; // Address of that write
  wire [31:0] wr_data; // Data of that write
  wire [3:0] wr_strb; // Byte enables of that write
  wire [ADDR_W-3:0] wr_index; // Word index of the write
  wire [ADDR_W-3:0] rd_index; // Word index of the read
  wire wr_status; // Write hits the status register
  wire wr_enable; // Write hits the enable register
  wire rd_status; // Read hits the status register
  wire rd_enable; // Read hits the enable register
  wire status_read; // Status read side effect this edge

  // Ready only while no answer is pending, one transfer at a time
  assign O_AWREADY = !aw_held_reg && !bvalid_reg;
  assign O_WREADY = !w_held_reg && !bvalid_reg;
  assign O_ARREADY = !rvalid_reg;

  assign aw_take = I_AWVALID && O_AWREADY;
  assign w_take = I_WVALID && O_WREADY;
  assign ar_take = I_ARVALID && O_ARREADY;

  // Address and data may arrive in either order or together
  assign aw_ok = aw_held_reg || aw_take;
  assign w_ok = w_held_reg || w_take;
  assign do_write = aw_ok && w_ok;
  assign wr_addr = aw_held_reg ? aw_addr_reg : I_AWADDR;
  assign wr_data = w_held_reg ? w_data_reg : I_WDATA;
  assign wr_strb = w_held_reg ? w_strb_reg : I_WSTRB;

  // Decode by word index; byte offset bits are ignored
  assign wr_index = wr_addr[ADDR_W-1:2];
  assign rd_index = I_ARADDR[ADDR_W-1:2];
  assign wr_status = (wr_index == `STATUS_REG_INDEX);
  assign wr_enable = (wr_index == `ENABLE_REG_INDEX);
  assign rd_status = (rd_index == `STATUS_REG_INDEX);
  assign rd_enable = (rd_index == `ENABLE_REG_INDEX);
  assign status_read = ar_take && rd_status;

  // Write channel: hold each half until the other arrives
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else begin
      if (do_write) begin
        // Both halves present: answer and release
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (wr_status || wr_enable) ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held_reg <= 1'b1;
          aw_addr_reg <= I_AWADDR;
        end
        if (w_take) begin
          w_held_reg <= 1'b1;
          w_data_reg <= I_WDATA;
          w_strb_reg <= I_WSTRB;
        end
        if (bvalid_reg && I_BREADY) begin
          bvalid_reg <= 1'b0;
        end
      end
    end
  end

  // Enable register; only byte lane 0 carries bits
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      enable_reg <= `ENABLE_RESET;
    end else if (do_write && wr_enable && wr_strb[0]) begin
      enable_reg <= wr_data[7:0];
    end
  end

  // Read channel: data captured at the handshake, so the value shown
  // is the one the clear acted on
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      if (rd_status) begin
        rdata_reg <= {24'h00_0000, status};
        rresp_reg <= `RESP_OKAY;
      end else if (rd_enable) begin
        rdata_reg <= {24'h00_0000, enable_reg};
        rresp_reg <= `RESP_OKAY;
      end else begin
        // Unmapped: zero data with an error answer
        rdata_reg <= 32'h0000_0000;
        rresp_reg <= `RESP_SLVERR;
      end
    end else if (rvalid_reg && I_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Previous detector state for change detection
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      code_prev_reg <= 1'b0;
    end else begin
      code_prev_reg <= i_code_detected;
    end
  end

  // Event pulses, latch order: 3 code, 2 end, 1 start, 0 tx done
  assign latch_set[3] = i_code_detected ^ code_prev_reg;
  assign latch_set[2] = i_rx_message_valid
    || i_rx_crc_error || i_rx_overrun || i_rx_abort;
  assign latch_set[1] = i_rx_opening_byte;
  assign latch_set[0] = i_tx_message_done;

  // A status read clears all four; a written one clears its bit too
  assign latch_clear[3] = status_read
    || (do_write && wr_status && wr_strb[0] && wr_data[`BIT_CODE_CHANGE]);
  assign latch_clear[2] = status_read
    || (do_write && wr_status && wr_strb[0] && wr_data[`BIT_RX_PACKET_END]);
  assign latch_clear[1] = status_read
    || (do_write && wr_status && wr_strb[0] && wr_data[`BIT_RX_PACKET_START]);
  assign latch_clear[0] = status_read
    || (do_write && wr_status && wr_strb[0] && wr_data[`BIT_TX_MESSAGE_DONE]);

  // One sticky flag per latched event
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_latch
      hdlc_event_latch u_latch (
        .i_clk(I_MCLK),
        .i_rst_n(I_RESET_N),
        .i_set(latch_set[g]),
        .i_clear(latch_clear[g]),
        .o_flag(latched[g])
      );
    end
  endgenerate

  // Live FIFO levels, order: 3 rx half, 2 rx not empty, 1 tx half, 0 room
  always @* begin
    level_next = 4'h0;
    level_next[3] = (i_rx_fifo_count > HALF_LEVEL);
    level_next[2] = (i_rx_fifo_count != {CNT_W{1'b0}});
    level_next[1] = (i_tx_fifo_count < HALF_LEVEL);
    level_next[0] = (i_tx_fifo_count < FULL_LEVEL);
  end

  // Registered levels; reads have no effect on them
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      level_reg <= 4'h0;
    end else begin
      level_reg <= level_next;
    end
  end

  // Status layout
  assign status[`BIT_CODE_CHANGE] = latched[3];
  assign status[`BIT_RX_PACKET_END] = latched[2];
  assign status[`BIT_RX_PACKET_START] = latched[1];
  assign status[`BIT_RX_HALF_FULL] = level_reg[3];
  assign status[`BIT_RX_NOT_EMPTY] = level_reg[2];
  assign status[`BIT_TX_HALF_EMPTY] = level_reg[1];
  assign status[`BIT_TX_HAS_ROOM] = level_reg[0];
  assign status[`BIT_TX_MESSAGE_DONE] = latched[0];

  // Next state of the sticky flags, mirroring the latch: set beats clear
  assign latched_next = latch_set | (latched & ~latch_clear);

  // Next enables, from the same write that loads the enable register
  assign enable_next = (do_write && wr_enable && wr_strb[0]) ? wr_data[7:0] : enable_reg;

  // Status one edge ahead, so the pin can come straight from a flop
  assign status_next[`BIT_CODE_CHANGE] = latched_next[3];
  assign status_next[`BIT_RX_PACKET_END] = latched_next[2];
  assign status_next[`BIT_RX_PACKET_START] = latched_next[1];
  assign status_next[`BIT_RX_HALF_FULL] = level_next[3];
  assign status_next[`BIT_RX_NOT_EMPTY] = level_next[2];
  assign status_next[`BIT_TX_HALF_EMPTY] = level_next[1];
  assign status_next[`BIT_TX_HAS_ROOM] = level_next[0];
  assign status_next[`BIT_TX_MESSAGE_DONE] = latched_next[0];

  // Interrupt low while any enabled flag stands; level flags keep it
  // low as long as their condition holds, so mask them when serviced.
  // Registered so decode glitches never reach the host's pin; built from
  // next values, so it moves on the same edge that latches the flag
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      int_n_reg <= 1'b1;
    end else begin
      int_n_reg <= ~|(status_next & enable_next);
    end
  end

  assign O_INT_N = int_n_reg;

  // Bus outputs
  assign O_BVALID = bvalid_reg;
  assign O_BRESP = bresp_reg;
  assign O_RVALID = rvalid_reg;
  assign O_RDATA = rdata_reg;
  assign O_RRESP = rresp_reg;

endmodule

// File: verification/hdlc_status_checker_props.sv
module hdlc_status_checker #(
  parameter ADDR_W = 8,
  parameter CNT_W = 7
) (
  input wire I_MCLK,
  input wire I_RESET_N,
  input wire i_code_detected,
  input wire i_rx_message_valid,
  input wire i_rx_crc_error,
  input wire i_rx_overrun,
  input wire i_rx_abort,
  input wire i_rx_opening_byte,
  input wire [CNT_W-1:0] i_rx_fifo_count,
  input wire [CNT_W-1:0] i_tx_fifo_count,
  input wire i_tx_message_done,
  input wire I_ARVALID,
  input wire O_ARREADY,
  input wire [ADDR_W-1:0] I_ARADDR,
  input wire O_RVALID,
  input wire [31:0] O_RDATA
);
  timeunit 1ns;
  timeprecision 1ns;
  // Any packet ending, good or faulty
  wire ends = i_rx_message_valid | i_rx_crc_error | i_rx_overrun | i_rx_abort;
  // Levels as bits 4..1 should show them
  wire [3:0] lv = {i_rx_fifo_count > 7'h20, i_rx_fifo_count != 7'h00,
    i_tx_fifo_count < 7'h20, i_tx_fifo_count < 7'h40};
  default clocking @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RESET_N);
  // Status read taken; first edge after reset excluded, history is stale there
  sequence s_rd;
    $past(I_RESET_N) && I_ARVALID && O_ARREADY && I_ARADDR == 8'h04;
  endsequence
  // No event source active
  sequence s_quiet;
    !(ends || i_rx_opening_byte || i_tx_message_done) && $stable(i_code_detected);
  endsequence
  a_code_change: assert property ($past(I_RESET_N) && $changed(i_code_detected)
    ##2 s_rd |=> O_RDATA[7])
    else $error("code change flag missing");
  a_packet_end: assert property (ends ##2 s_rd |=> O_RDATA[6])
    else $error("packet end flag missing");
  a_packet_start: assert property (i_rx_opening_byte ##2 s_rd |=> O_RDATA[5])
    else $error("packet start flag missing");
  a_message_done: assert property (i_tx_message_done ##2 s_rd |=> O_RDATA[0])
    else $error("message done flag missing");
  a_live_levels: assert property (s_rd ##0 $stable(lv)
    |=> O_RDATA[4:1] == $past(lv))
    else $error("level flags wrong");
  a_read_clears: assert property (s_rd ##0 s_quiet [*4] ##0 s_rd
    |=> (O_RDATA[7:0] & 8'hE1) == 8'h00)
    else $error("latched flag survived read");
  a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer late");
  a_upper_zero: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h00_0000)
    else $error("upper read bits set");
endmodule

bind hdlc_status_interrupt_mask hdlc_status_checker #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) i_chk (
  .I_MCLK, .I_RESET_N, .i_code_detected, .i_rx_message_valid, .i_rx_crc_error, .i_rx_overrun,
  .i_rx_abort, .i_rx_opening_byte, .i_rx_fifo_count, .i_tx_fifo_count, .i_tx_message_done,
  .I_ARVALID, .O_ARREADY, .I_ARADDR, .O_RVALID, .O_RDATA);

// File: verification/hdlc_host_model.sv
module hdlc_host_model (
  input wire i_clk,
  output logic o_awv = 1'b0,
  output logic o_wv = 1'b0,
  output logic o_bry = 1'b0,
  output logic o_arv = 1'b0,
  output logic o_rry = 1'b0,
  output logic [7:0] o_a = 8'h00,
  output logic [31:0] o_wd = 32'h0000_0000,
  output logic o_hung = 1'b0,
  input wire i_awr,
  input wire i_wr,
  input wire i_bv,
  input wire [1:0] i_br,
  input wire i_arr,
  input wire i_rv,
  input wire [31:0] i_rd,
  input wire [1:0] i_rr
);
  timeunit 1ns;
  timeprecision 1ns;
  // One bus cycle; handshakes judged at the falling edge, acted on at the next rise
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [31:0] q, output logic [1:0] r);
    int n;
    logic ta, tw, tr;
    n = 0;
    tr = 1'b0;
    @(posedge i_clk);
    o_awv <= w;
    o_wv <= w;
    o_bry <= w;
    o_arv <= !w;
    o_rry <= !w;
    o_a <= a;
    o_wd <= {24'h00_0000, d};
    while (!tr && n < 40) begin
      @(negedge i_clk);
      ta = (o_awv && i_awr) || (o_arv && i_arr);
      tw = o_wv && i_wr;
      tr = (o_bry && i_bv) || (o_rry && i_rv);
      q = i_rd;
      r = w ? i_br : i_rr;
      @(posedge i_clk);
      n++;
      // Released lines scrambled so no stale value looks valid
      if (ta) o_awv <= 1'b0;
      if (ta) o_arv <= 1'b0;
      if (ta) o_a <= ~a;
      if (tw) o_wv <= 1'b0;
      if (tw) o_wd <= ~o_wd;
      if (tr) o_bry <= 1'b0;
      if (tr) o_rry <= 1'b0;
    end
    if (!tr) o_hung <= 1'b1;
  endtask
endmodule

// File: verification/hdlc_status_interrupt_mask_test.sv
module hdlc_status_interrupt_mask_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic code = 1'b0;
  logic [5:0] ev = 6'h00; // 0 done, 1 start, 2 valid, 3 crc, 4 overrun, 5 abort
  logic [6:0] rxc = 7'h00;
  logic [6:0] txc = 7'h00;
  wire awv, wv, bry, arv, rry, hung, awrdy, wrdy, bv, arrdy, rv, int_n;
  wire [7:0] adr;
  wire [31:0] wd, rd;
  wire [1:0] br, rr;
  int fail_count = 0;
  int num_checks = 0;
  logic [31:0] got;
  logic [1:0] resp;
  hdlc_status_interrupt_mask i_hdlc_status_interrupt_mask (.I_MCLK(clk), .I_RESET_N(rst_n),
    .i_code_detected(code), .i_rx_message_valid(ev[2]), .i_rx_crc_error(ev[3]),
    .i_rx_overrun(ev[4]), .i_rx_abort(ev[5]), .i_rx_opening_byte(ev[1]),
    .i_rx_fifo_count(rxc), .i_tx_fifo_count(txc), .i_tx_message_done(ev[0]), .O_INT_N(int_n),
    .I_AWVALID(awv), .O_AWREADY(awrdy), .I_AWADDR(adr), .I_AWPROT(3'h0), .I_WVALID(wv),
    .O_WREADY(wrdy), .I_WDATA(wd), .I_WSTRB(4'hF), .O_BVALID(bv), .I_BREADY(bry), .O_BRESP(br),
    .I_ARVALID(arv), .O_ARREADY(arrdy), .I_ARADDR(adr), .I_ARPROT(3'h0), .O_RVALID(rv),
    .I_RREADY(rry), .O_RDATA(rd), .O_RRESP(rr));
  hdlc_host_model i_hdlc_host_model (.i_clk(clk), .o_awv(awv), .o_wv(wv), .o_bry(bry),
    .o_arv(arv), .o_rry(rry), .o_a(adr), .o_wd(wd), .o_hung(hung), .i_awr(awrdy), .i_wr(wrdy),
    .i_bv(bv), .i_br(br), .i_arr(arrdy), .i_rv(rv), .i_rd(rd), .i_rr(rr));
  // Verdict and end of run
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Compare any word
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // Compare a bus answer code
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t answer %h want %h", $time, g, e);
    end
  endtask
  // Mapped words answer OKAY, others the error code
  function automatic logic [1:0] rexp(input logic [7:0] a);
    return (a == 8'h04 || a == 8'h08) ? 2'h0 : 2'h2;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_hdlc_host_model.xfer(1'b1, a, d, got, resp);
    chk_resp(resp, rexp(a));
  endtask
  task automatic rs(input logic [7:0] a, input logic [31:0] e);
    i_hdlc_host_model.xfer(1'b0, a, 8'h00, got, resp);
    chk_resp(resp, rexp(a));
    chk(got, e);
  endtask
  // One event source for a cycle; index 6 toggles the code detector
  task automatic pulse(input int k);
    @(posedge clk);
    if (k == 6) code <= ~code;
    else ev[k] <= 1'b1;
    @(posedge clk);
    ev <= 6'h00;
  endtask
  // Compare the interrupt pin where it is settled
  task automatic int_is(input logic e);
    @(negedge clk);
    num_checks++;
    if (int_n !== e) begin
      fail_count++;
      $display("[ERR] %0t interrupt %b want %b", $time, int_n, e);
    end
  endtask
  // Reset value, readback, unmapped word has no effect
  task automatic t_regs;
    rs(8'h08, 32'h0000_0000);
    wr(8'h08, 8'hA5);
    wr(8'h0C, 8'h5A);
    rs(8'h0C, 32'h0000_0000);
    rs(8'h08, 32'h0000_00A5);
  endtask
  // Each source alone sets its flag; the next read finds it gone
  task automatic t_events;
    logic [7:0] bits [7] = '{8'h01, 8'h20, 8'h40, 8'h40, 8'h40, 8'h40, 8'h80};
    for (int k = 0; k < 7; k++) begin
      pulse(k);
      rs(8'h04, {24'h0, bits[k] | 8'h06});
      rs(8'h04, 32'h0000_0006);
    end
  endtask
  // Occupancy boundaries, read twice so a read must leave them alone
  task automatic t_levels;
    logic [6:0] rx [5] = '{7'h00, 7'h01, 7'h20, 7'h21, 7'h40};
    logic [6:0] tx [5] = '{7'h40, 7'h3F, 7'h20, 7'h1F, 7'h00};
    logic [31:0] want;
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      rxc <= rx[k];
      txc <= tx[k];
      want = {27'h0, rx[k] > 7'h20, rx[k] != 7'h00, tx[k] < 7'h20, tx[k] < 7'h40, 1'b0};
      repeat (2) rs(8'h04, want);
    end
  endtask
  // Writing a one clears a latched flag, a zero keeps it; level bits ignore writes
  task automatic t_w1c;
    pulse(1);
    wr(8'h04, 8'hDF);
    rs(8'h04, 32'h0000_0026);
    pulse(1);
    wr(8'h04, 8'h20);
    rs(8'h04, 32'h0000_0006);
  endtask
  // Masking, pending event unmasked later, release by read, live level source
  task automatic t_int;
    wr(8'h08, 8'h00);
    int_is(1'b1);
    pulse(0);
    int_is(1'b1);
    wr(8'h08, 8'h01);
    int_is(1'b0);
    rs(8'h04, 32'h0000_001F);
    int_is(1'b1);
    wr(8'h08, 8'h02);
    int_is(1'b0);
    @(posedge clk);
    txc <= 7'h40;
    @(posedge clk);
    int_is(1'b1);
  endtask
  initial begin
    forever #50 clk = ~clk;
  end
  // A stuck bus cycle ends the run
  always @(posedge hung) begin
    fail_count++;
    wrap_up;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_events;
    t_w1c;
    t_levels;
    t_int;
    wrap_up;
  end
endmodule
